/* File: include/dsssf_pkg.sv */
`default_nettype none
package dsssf_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_SHORT_LEN  = 8'h00;
  localparam logic [7:0] OFF_LONG_LEN   = 8'h04;
  localparam logic [7:0] OFF_TX_SETUP   = 8'h08;
  localparam logic [7:0] OFF_SERVICE    = 8'h0c;
  localparam logic [7:0] OFF_LEN_A      = 8'h10;
  localparam logic [7:0] OFF_LEN_B      = 8'h14;
  localparam logic [7:0] OFF_RX_STATUS  = 8'h18;
  localparam logic [7:0] OFF_RX_RATE    = 8'h1c;
  localparam logic [7:0] OFF_SCR_CTRL   = 8'h20;
  localparam logic [7:0] OFF_LONG_SEED  = 8'h24;
  localparam logic [7:0] OFF_SHORT_SEED = 8'h28;
  localparam logic [7:0] OFF_ROT_CTRL   = 8'h2c;
  localparam logic [7:0] OFF_RX_SERVICE = 8'h30;
  localparam logic [7:0] OFF_RX_LENGTH  = 8'h34;
  // Field positions
  localparam int SETUP_SHORT_BIT = 2;
  localparam int SCR_DIS_BIT     = 2;
  localparam int ROT_TX_BIT      = 6;
  localparam int ROT_RX_BIT      = 7;
  localparam int ST_SFD_BIT      = 0;
  localparam int ST_SHORT_BIT    = 1;
  localparam int ST_CRC_ERR_BIT  = 2;
  localparam int ST_VALID_BIT    = 3;
  localparam int SVC_LOCKED_BIT  = 2;
  localparam int RX_RATE_LSB     = 6;
  // Reset values
  localparam logic [7:0] RST_SHORT_LEN = 8'h38;
  localparam logic [7:0] RST_LONG_LEN  = 8'h80;
  localparam logic [7:0] RST_SERVICE   = 8'h04;
  localparam logic [6:0] RST_SEED      = 7'h6c;
  // Frame constants
  localparam logic [15:0] SFD_LONG   = 16'hf3a0;
  localparam logic [15:0] SFD_SHORT  = 16'h05cf;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [8:0]  SFD_BITS   = 9'h010;
  localparam logic [5:0]  HDR_BITS   = 6'h20;
  localparam logic [5:0]  CRC_BITS   = 6'h10;
  localparam logic [5:0]  TAIL_BITS  = 6'h08;
  localparam logic [5:0]  SCR_BITS   = 6'h07;
  // Signal field per rate code 00..11
  localparam logic [7:0] SIG_1M  = 8'h0a;
  localparam logic [7:0] SIG_2M  = 8'h14;
  localparam logic [7:0] SIG_5M5 = 8'h37;
  localparam logic [7:0] SIG_11M = 8'h6e;
  // Timing: 1 us symbol at 25 ns clock
  localparam int CLK_NS    = 25;
  localparam int SYM_NS    = 1000;
  localparam int SYM_DIV   = SYM_NS / CLK_NS;
  localparam int HALF_DIV  = SYM_DIV / 2;

  typedef enum logic [1:0] {
    RATE_1M, RATE_2M, RATE_5M5, RATE_11M
  } dsssf_rate_t;

  typedef struct packed {
    logic [7:0]  short_len;
    logic [7:0]  long_len;
    logic [1:0]  rate;
    logic        short_pre;
    logic [7:0]  service;
    logic [15:0] length;
    logic        scr_dis;
    logic [6:0]  long_seed;
    logic [6:0]  short_seed;
    logic        rot_tx;
    logic        rot_rx;
  } dsssf_cfg_t;
endpackage : dsssf_pkg
`default_nettype wire

/* File: rtl/dsssf_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dsssf_top import dsssf_pkg::*; #(
  parameter int SYM_CYCLES = SYM_DIV
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmit side
  input  wire logic        tx_path_enable,
  input  wire logic        tx_data_bit,
  output logic             tx_data_req,
  output logic             tx_i,
  output logic             tx_q,
  output logic             tx_busy,
  // Receive side
  input  wire logic        rx_path_enable,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  output logic             rx_data_valid,
  output logic             rx_data_bit,
  output logic [1:0]       rx_demod_rate,
  output logic             rx_hdr_dqpsk,
  output logic             rx_rot_reverse
);
  function automatic logic [15:0] crc_step(logic [15:0] c, logic b);
    logic fb;
    fb = c[15] ^ b;
    return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  function automatic logic scr_out(logic [6:0] r, logic b);
    return b ^ r[3] ^ r[6];
  endfunction : scr_out

  function automatic logic [7:0] sig_code(logic [1:0] r);
    case (r)
      2'b00:   return SIG_1M;
      2'b01:   return SIG_2M;
      2'b10:   return SIG_5M5;
      default: return SIG_11M;
    endcase
  endfunction : sig_code

  // Configuration registers and APB slave
  dsssf_cfg_t  cfg_reg;
  logic        crc_err_reg;
  logic        crc_err_set;
  logic [7:0]  rx_rate_reg;
  logic [15:0] rx_length_reg;
  logic [7:0]  rx_service_reg;
  logic        rx_short_reg;
  logic        sfd_seen;
  logic        wr_en;
  logic        mapped;

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= OFF_RX_LENGTH);
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg            <= '0;
      cfg_reg.short_len  <= RST_SHORT_LEN;
      cfg_reg.long_len   <= RST_LONG_LEN;
      cfg_reg.service    <= RST_SERVICE;
      cfg_reg.long_seed  <= RST_SEED;
      cfg_reg.short_seed <= RST_SEED;
    end else if (wr_en) begin
      case (paddr)
        OFF_SHORT_LEN:  cfg_reg.short_len <= pwdata[7:0];
        OFF_LONG_LEN:   cfg_reg.long_len  <= pwdata[7:0];
        OFF_TX_SETUP: begin
          cfg_reg.rate      <= pwdata[1:0];
          cfg_reg.short_pre <= pwdata[SETUP_SHORT_BIT];
        end
        OFF_SERVICE:    cfg_reg.service <= pwdata[7:0];
        OFF_LEN_A:      cfg_reg.length[7:0]  <= pwdata[7:0];
        OFF_LEN_B:      cfg_reg.length[15:8] <= pwdata[7:0];
        OFF_SCR_CTRL:   cfg_reg.scr_dis <= pwdata[SCR_DIS_BIT];
        OFF_LONG_SEED:  cfg_reg.long_seed  <= pwdata[6:0];
        OFF_SHORT_SEED: cfg_reg.short_seed <= pwdata[6:0];
        OFF_ROT_CTRL: begin
          cfg_reg.rot_tx <= pwdata[ROT_TX_BIT];
          cfg_reg.rot_rx <= pwdata[ROT_RX_BIT];
        end
        default: ;
      endcase
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFF_SHORT_LEN:  prdata <= {24'h0, cfg_reg.short_len};
        OFF_LONG_LEN:   prdata <= {24'h0, cfg_reg.long_len};
        OFF_TX_SETUP:   prdata <= {29'h0, cfg_reg.short_pre, cfg_reg.rate};
        OFF_SERVICE:    prdata <= {24'h0, cfg_reg.service};
        OFF_LEN_A:      prdata <= {24'h0, cfg_reg.length[7:0]};
        OFF_LEN_B:      prdata <= {24'h0, cfg_reg.length[15:8]};
        OFF_RX_STATUS:  prdata <= {28'h0, rx_data_valid, crc_err_reg,
                                   rx_short_reg, sfd_seen};
        OFF_RX_RATE:    prdata <= {24'h0, rx_rate_reg};
        OFF_SCR_CTRL:   prdata <= {29'h0, cfg_reg.scr_dis, 2'b00};
        OFF_LONG_SEED:  prdata <= {25'h0, cfg_reg.long_seed};
        OFF_SHORT_SEED: prdata <= {25'h0, cfg_reg.short_seed};
        OFF_ROT_CTRL:   prdata <= {24'h0, cfg_reg.rot_rx, cfg_reg.rot_tx,
                                   6'h00};
        OFF_RX_SERVICE: prdata <= {24'h0, rx_service_reg};
        OFF_RX_LENGTH:  prdata <= {16'h0, rx_length_reg};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // CRC error flag: hardware set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_err_reg <= 1'b0;
    end else if (crc_err_set) begin
      crc_err_reg <= 1'b1;
    end else if (wr_en && paddr == OFF_RX_STATUS
                 && pwdata[ST_CRC_ERR_BIT]) begin
      crc_err_reg <= 1'b0;
    end
  end

  // Transmit framer
  typedef enum logic [2:0] {
    T_IDLE, T_PRE, T_SFD, T_HDR, T_CRC, T_DATA, T_TAIL, T_DONE
  } dsssf_tx_state_t;

  dsssf_tx_state_t tx_state_reg;
  logic [7:0]  tx_cnt_reg;
  logic [5:0]  tx_div_reg;
  logic [6:0]  tx_scr_reg;
  logic [15:0] tx_crc_reg;
  logic [31:0] tx_hdr;
  logic [1:0]  tx_phase_reg;
  logic        tx_first_reg;
  logic        tx_half_reg;
  logic        tx_short_reg;
  logic        tx_fast;
  logic        tx_fast_next;
  logic        tx_tick;
  logic        tx_raw;
  logic        tx_scr;
  logic [1:0]  tx_step;

  assign tx_hdr = {cfg_reg.length, cfg_reg.service, sig_code(cfg_reg.rate)};
  assign tx_fast = ((tx_state_reg == T_HDR || tx_state_reg == T_CRC)
                    && tx_short_reg)
                   || ((tx_state_reg == T_DATA || tx_state_reg == T_TAIL)
                       && cfg_reg.rate != RATE_1M);
  // Speed of the bit timed by the next reload, segment changes included
  assign tx_fast_next = tx_state_reg == T_SFD
                        && tx_cnt_reg == 8'(SFD_BITS - 9'h001) ? tx_short_reg
                      : tx_state_reg == T_CRC
                        && tx_cnt_reg == 8'(CRC_BITS - 6'h01)
                        ? cfg_reg.rate != RATE_1M : tx_fast;
  assign tx_tick = (tx_div_reg == 6'h00) && tx_state_reg != T_IDLE
                   && tx_state_reg != T_DONE;
  assign tx_data_req = tx_tick && tx_state_reg == T_DATA && tx_path_enable;
  assign tx_busy = tx_state_reg != T_IDLE;

  always_comb begin
    case (tx_state_reg)
      T_PRE:   tx_raw = ~tx_short_reg;
      T_SFD:   tx_raw = tx_short_reg ? SFD_SHORT[tx_cnt_reg[3:0]]
                                     : SFD_LONG[tx_cnt_reg[3:0]];
      T_HDR:   tx_raw = tx_hdr[tx_cnt_reg[4:0]];
      T_CRC:   tx_raw = ~tx_crc_reg[15];
      T_DATA:  tx_raw = tx_data_bit;
      default: tx_raw = 1'b0;
    endcase
  end

  assign tx_scr = cfg_reg.scr_dis ? tx_raw
                                  : scr_out(tx_scr_reg, tx_raw);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_div_reg <= 6'h00;
    end else if (tx_state_reg == T_IDLE || tx_div_reg == 6'h00) begin
      tx_div_reg <= tx_fast_next ? 6'(SYM_CYCLES / 2 - 1) : 6'(SYM_CYCLES - 1);
    end else begin
      tx_div_reg <= tx_div_reg - 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= T_IDLE;
      tx_cnt_reg   <= 8'h00;
      tx_short_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        T_IDLE: if (tx_path_enable) begin
          tx_state_reg <= T_PRE;
          tx_short_reg <= cfg_reg.short_pre;
          tx_cnt_reg   <= 8'h00;
        end
        default: if (tx_tick) begin
          tx_cnt_reg <= tx_cnt_reg + 8'h01;
          case (tx_state_reg)
            T_PRE: if (tx_cnt_reg + 8'h01 == (tx_short_reg ? cfg_reg.short_len
                                        : cfg_reg.long_len)) begin
              tx_state_reg <= T_SFD;
              tx_cnt_reg   <= 8'h00;
            end
            T_SFD: if (tx_cnt_reg == 8'(SFD_BITS - 9'h001)) begin
              tx_state_reg <= T_HDR;
              tx_cnt_reg   <= 8'h00;
            end
            T_HDR: if (tx_cnt_reg == 8'(HDR_BITS - 6'h01)) begin
              tx_state_reg <= T_CRC;
              tx_cnt_reg   <= 8'h00;
            end
            T_CRC: if (tx_cnt_reg == 8'(CRC_BITS - 6'h01)) begin
              tx_state_reg <= T_DATA;
              tx_cnt_reg   <= 8'h00;
            end
            T_DATA: if (!tx_path_enable) begin
              tx_state_reg <= T_TAIL;
              tx_cnt_reg   <= 8'h00;
            end
            T_TAIL: if (tx_cnt_reg == 8'(TAIL_BITS - 6'h01)) begin
              tx_state_reg <= T_DONE;
            end
            default: ;
          endcase
        end else if (tx_state_reg == T_DONE && !tx_path_enable) begin
          tx_state_reg <= T_IDLE;
        end
      endcase
    end
  end

  // CRC over the header fields, ahead of scrambling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_crc_reg <= CRC_PRESET;
    end else if (tx_state_reg == T_IDLE) begin
      tx_crc_reg <= CRC_PRESET;
    end else if (tx_tick && tx_state_reg == T_HDR) begin
      tx_crc_reg <= crc_step(tx_crc_reg, tx_raw);
    end else if (tx_tick && tx_state_reg == T_CRC) begin
      tx_crc_reg <= {tx_crc_reg[14:0], 1'b1};
    end
  end

  // Scrambler with per-preamble seed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_scr_reg <= RST_SEED;
    end else if (tx_state_reg == T_IDLE) begin
      tx_scr_reg <= cfg_reg.short_pre ? cfg_reg.short_seed
                                      : cfg_reg.long_seed;
    end else if (tx_tick) begin
      tx_scr_reg <= {tx_scr_reg[5:0], tx_scr};
    end
  end

  // Dibit phase step, sense reversible
  always_comb begin
    case ({tx_first_reg, tx_scr})
      2'b01:   tx_step = cfg_reg.rot_tx ? 2'd3 : 2'd1;
      2'b11:   tx_step = 2'd2;
      2'b10:   tx_step = cfg_reg.rot_tx ? 2'd1 : 2'd3;
      default: tx_step = 2'd0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_phase_reg <= 2'd0;
      tx_first_reg <= 1'b0;
      tx_half_reg  <= 1'b0;
    end else if (tx_state_reg == T_IDLE) begin
      tx_phase_reg <= 2'd0;
      tx_half_reg  <= 1'b0;
    end else if (tx_tick && !tx_fast) begin
      tx_phase_reg <= tx_phase_reg + {tx_scr, 1'b0};
      tx_half_reg  <= 1'b0;
    end else if (tx_tick && !tx_half_reg) begin
      tx_first_reg <= tx_scr;
      tx_half_reg  <= 1'b1;
    end else if (tx_tick) begin
      tx_phase_reg <= tx_phase_reg + tx_step;
      tx_half_reg  <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_i <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      tx_i <= tx_phase_reg[1];
      tx_q <= tx_phase_reg[1] ^ tx_phase_reg[0];
    end
  end

  // Receive header checker
  typedef enum logic [2:0] {
    R_OFF, R_INIT, R_HUNT, R_HDR, R_CRC, R_DATA
  } dsssf_rx_state_t;

  dsssf_rx_state_t rx_state_reg;
  logic [6:0]  rx_scr_reg;
  logic [15:0] rx_sfd_reg;
  logic [31:0] rx_hdr_reg;
  logic [15:0] rx_crc_reg;
  logic [15:0] rx_fcs_reg;
  logic [8:0]  rx_cnt_reg;
  logic        rx_db;
  logic        rx_sig_ok;
  logic [1:0]  rx_code;
  logic [8:0]  rx_limit;

  assign rx_db = cfg_reg.scr_dis ? rx_bit
                                 : scr_out(rx_scr_reg, rx_bit);
  assign rx_limit = {1'b0, rx_short_reg ? cfg_reg.short_len
                                        : cfg_reg.long_len} + SFD_BITS;
  assign sfd_seen = rx_state_reg == R_HDR || rx_state_reg == R_CRC
                    || rx_state_reg == R_DATA;
  assign rx_hdr_dqpsk   = rx_short_reg;
  assign rx_rot_reverse = cfg_reg.rot_rx;

  always_comb begin
    rx_sig_ok = 1'b1;
    case (rx_hdr_reg[7:0])
      SIG_1M:  rx_code = 2'b00;
      SIG_2M:  rx_code = 2'b01;
      SIG_5M5: rx_code = 2'b10;
      SIG_11M: rx_code = 2'b11;
      default: begin
        rx_code   = 2'b00;
        rx_sig_ok = 1'b0;
      end
    endcase
  end

  assign crc_err_set = rx_bit_valid && rx_path_enable && rx_state_reg == R_CRC
                       && rx_cnt_reg == 9'(CRC_BITS - 6'h01)
                       && {rx_fcs_reg[14:0], rx_db} != ~rx_crc_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_scr_reg <= 7'h00;
      rx_sfd_reg <= 16'h0000;
      rx_hdr_reg <= 32'h0;
      rx_fcs_reg <= 16'h0000;
    end else if (rx_bit_valid) begin
      rx_scr_reg <= {rx_scr_reg[5:0], rx_bit};
      rx_sfd_reg <= {rx_db, rx_sfd_reg[15:1]};
      if (rx_state_reg == R_HDR) begin
        rx_hdr_reg <= {rx_db, rx_hdr_reg[31:1]};
      end
      if (rx_state_reg == R_CRC) begin
        rx_fcs_reg <= {rx_fcs_reg[14:0], rx_db};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_crc_reg <= CRC_PRESET;
    end else if (rx_state_reg != R_HDR && rx_state_reg != R_CRC) begin
      rx_crc_reg <= CRC_PRESET;
    end else if (rx_bit_valid && rx_state_reg == R_HDR) begin
      rx_crc_reg <= crc_step(rx_crc_reg, rx_db);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg   <= R_OFF;
      rx_cnt_reg     <= 9'h000;
      rx_short_reg   <= 1'b0;
      rx_rate_reg    <= 8'h00;
      rx_service_reg <= 8'h00;
      rx_length_reg  <= 16'h0000;
    end else if (!rx_path_enable) begin
      rx_state_reg <= R_OFF;
    end else if (rx_state_reg == R_OFF) begin
      rx_state_reg <= R_INIT;
      rx_cnt_reg   <= 9'h000;
    end else if (rx_bit_valid) begin
      rx_cnt_reg <= rx_cnt_reg + 9'h001;
      case (rx_state_reg)
        R_INIT: if (rx_cnt_reg == 9'(SCR_BITS - 6'h01)) begin
          rx_state_reg <= R_HUNT;
          rx_cnt_reg   <= 9'h000;
        end
        R_HUNT: begin
          rx_short_reg <= ~rx_db;
          if ({rx_db, rx_sfd_reg[15:1]} == SFD_LONG
              || {rx_db, rx_sfd_reg[15:1]} == SFD_SHORT) begin
            rx_state_reg <= R_HDR;
            rx_short_reg <= {rx_db, rx_sfd_reg[15:1]} == SFD_SHORT;
            rx_cnt_reg   <= 9'h000;
          end else if (rx_cnt_reg >= rx_limit) begin
            rx_state_reg <= R_INIT;
            rx_cnt_reg   <= 9'h000;
          end
        end
        R_HDR: if (rx_cnt_reg == 9'(HDR_BITS - 6'h01)) begin
          rx_state_reg <= R_CRC;
          rx_cnt_reg   <= 9'h000;
        end
        R_CRC: if (rx_cnt_reg == 9'(CRC_BITS - 6'h01)) begin
          rx_cnt_reg <= 9'h000;
          if (crc_err_set || !rx_sig_ok) begin
            rx_state_reg <= R_INIT;
          end else begin
            rx_state_reg   <= R_DATA;
            rx_rate_reg    <= {rx_code, 6'h00};
            rx_service_reg <= rx_hdr_reg[15:8];
            rx_length_reg  <= rx_hdr_reg[31:16];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_valid <= 1'b0;
      rx_data_bit   <= 1'b0;
      rx_demod_rate <= 2'b00;
    end else begin
      rx_data_valid <= rx_state_reg == R_DATA && rx_path_enable;
      rx_data_bit   <= rx_db;
      rx_demod_rate <= rx_state_reg == R_DATA
                       ? rx_rate_reg[RX_RATE_LSB +: 2] : 2'b00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_valid_after_sfd;
    $rose(rx_data_valid) |-> $past(rx_state_reg) == R_DATA;
  endproperty
  a_valid_after_sfd: assert property (p_valid_after_sfd)
    else $error("valid without SFD");

  property p_crc_err;
    crc_err_set |=> crc_err_reg && rx_state_reg == R_INIT ##1 !rx_data_valid;
  endproperty
  a_crc_err: assert property (p_crc_err)
    else $error("crc error not handled");

  property p_req_only_data;
    tx_data_req |-> tx_state_reg == T_DATA;
  endproperty
  a_req_only_data: assert property (p_req_only_data)
    else $error("data request outside payload");

  property p_dbpsk_iq;
    tx_state_reg == T_HDR && !tx_short_reg ##2 1'b1 |-> tx_i == tx_q;
  endproperty
  a_dbpsk_iq: assert property (p_dbpsk_iq)
    else $error("I and Q differ in DBPSK");

  property p_bypass;
    cfg_reg.scr_dis && tx_tick |=> tx_scr_reg[0] == $past(tx_raw);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("scrambler not bypassed");

  property p_seed;
    tx_state_reg == T_IDLE && tx_path_enable |=>
      tx_scr_reg == (tx_short_reg ? cfg_reg.short_seed : cfg_reg.long_seed);
  endproperty
  a_seed: assert property (p_seed)
    else $error("wrong scrambler seed");

  sequence s_hdr_done;
    tx_tick && tx_state_reg == T_HDR && tx_cnt_reg == 8'd31;
  endsequence
  property p_crc_follows;
    s_hdr_done |=> tx_state_reg == T_CRC && tx_cnt_reg == 8'd0;
  endproperty
  a_crc_follows: assert property (p_crc_follows)
    else $error("CRC does not follow header");

  property p_short_fast;
    tx_state_reg == T_HDR && tx_short_reg |-> tx_fast;
  endproperty
  a_short_fast: assert property (p_short_fast)
    else $error("short header not at 2 Mbps");
endmodule : dsssf_top
`default_nettype wire

/* File: test/dsssf_mac_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dsssf_mac_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench control
  input  wire logic       go,
  input  wire logic [7:0] npay,
  output logic      [7:0] sent,
  // Transmit path
  input  wire logic       tx_data_req,
  output logic            tx_path_enable,
  output logic            tx_data_bit
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_path_enable <= 1'b0;
      sent           <= 8'h00;
    end else if (go && !tx_path_enable) begin
      tx_path_enable <= 1'b1;
      sent           <= 8'h00;
    end else if (tx_data_req && tx_path_enable) begin
      sent <= sent + 8'h01;
      if (sent + 8'h01 == npay) tx_path_enable <= 1'b0;
    end
  end
  assign tx_data_bit = sent[0] ^ sent[2];
endmodule : dsssf_mac_model
`default_nettype wire

/* File: test/dsssf_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dsssf_top_tb;
  import dsssf_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, sent;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, go = 0, txe, txb, req, busy;
  logic        rxe = 0, rxv = 0, rxb = 0, rdv, rdb, rdq, rrot, ti, tq;
  logic [1:0]  rrate;
  int          num_errors = 0, samples_checked = 0, cyc = 0, t0;
  always #12.5 pclk = ~pclk;
  dsssf_top #(.SYM_CYCLES(8)) i_dsssf_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_path_enable(txe), .tx_data_bit(txb), .tx_data_req(req), .tx_i(ti),
    .tx_q(tq), .tx_busy(busy), .rx_path_enable(rxe), .rx_bit_valid(rxv),
    .rx_bit(rxb), .rx_data_valid(rdv), .rx_data_bit(rdb),
    .rx_demod_rate(rrate), .rx_hdr_dqpsk(rdq), .rx_rot_reverse(rrot));
  dsssf_mac_model i_dsssf_mac_model (.pclk(pclk), .presetn(presetn),
    .go(go), .npay(8'h05), .sent(sent), .tx_data_req(req),
    .tx_path_enable(txe), .tx_data_bit(txb));
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic t_regs;
    apb(0, OFF_SHORT_LEN, 0); chk("short_len", rd, 32'h38);
    apb(0, OFF_LONG_LEN, 0); chk("long_len", rd, 32'h80);
    apb(0, OFF_SERVICE, 0); chk("service", rd, 32'h04);
    apb(1, OFF_LEN_A, 32'h5a); apb(1, OFF_LEN_B, 32'h1c);
    apb(0, OFF_LEN_B, 0); chk("len_b", rd, 32'h1c);
    apb(1, 8'h3c, 32'h7); chk("unmapped err", {31'h0, er}, 32'h1);
    apb(0, 8'h3c, 0); chk("unmapped data", rd, 32'h0);
    apb(1, OFF_ROT_CTRL, 32'h80);
    apb(0, OFF_ROT_CTRL, 0);
    chk("rot ctrl", rd, 32'h80);
    chk("rot rx", {31'h0, rrot}, 32'h1);
  endtask : t_regs
  task automatic t_tx(input logic shrt, input int lo, hi);
    apb(1, shrt ? OFF_SHORT_LEN : OFF_LONG_LEN, 32'h10);
    apb(1, OFF_TX_SETUP, shrt ? 32'h6 : 32'h0);
    go <= 1; t0 = cyc;
    @(posedge pclk) go <= 0;
    while (req !== 1'b1) @(posedge pclk);
    chk("payload start", {31'h0, (cyc - t0) inside {[lo:hi]}}, 1);
    if (!shrt) chk("dbpsk iq", {31'h0, ti}, {31'h0, tq});
    while (busy !== 1'b0) @(posedge pclk);
    chk("payload bits", {24'h0, sent}, 32'h5);
  endtask : t_tx
  function automatic logic [15:0] crc(input logic [31:0] h);
    logic [15:0] c = CRC_PRESET;
    for (int i = 0; i < 32; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ h[i]) ? CRC_POLY : 16'h0);
    return ~c;
  endfunction : crc
  task automatic send(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk); rxv <= 1; rxb <= v[i];
      @(posedge pclk) rxv <= 0;
      repeat (2) @(posedge pclk);
    end
  endtask : send
  task automatic t_rx(input logic bad, shrt, input logic [7:0] sig,
                      input logic [1:0] code);
    logic [31:0] h = {16'h0040, 8'h04, sig};
    logic [15:0] c = crc(h) ^ {15'h0, bad};
    logic [15:0] cr = {<<{c}};
    rxe <= 1;
    send(shrt ? 64'h0 : 64'hffff, 16);
    send(shrt ? SFD_SHORT : SFD_LONG, 16);
    send({15'h0, 1'b1, cr, h}, 49);
    repeat (4) @(posedge pclk);
    chk("rx valid", {31'h0, rdv}, {31'h0, !bad});
    chk("rx short", {31'h0, rdq}, {31'h0, shrt});
    if (!bad) begin
      chk("rx rate", {30'h0, rrate}, {30'h0, code});
      chk("rx data", {31'h0, rdb}, 32'h1);
      apb(0, OFF_RX_SERVICE, 0);
      chk("rx service", rd, 32'h04);
      apb(0, OFF_RX_LENGTH, 0);
      chk("rx length", rd, 32'h40);
    end
    apb(0, OFF_RX_STATUS, 0);
    chk("crc err", {31'h0, rd[ST_CRC_ERR_BIT]}, {31'h0, bad});
    rxe <= 0;
    apb(1, OFF_RX_STATUS, 32'h4);
  endtask : t_rx
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs();
    apb(1, OFF_SCR_CTRL, 32'h4);
    apb(0, OFF_SCR_CTRL, 0);
    chk("scr ctrl", rd, 32'h4);
    t_tx(0, 640, 680);
    t_tx(1, 440, 480);
    t_rx(0, 0, SIG_2M, 2'b01);
    t_rx(1, 0, SIG_2M, 2'b01);
    t_rx(0, 1, SIG_11M, 2'b11);
    give_verdict();
  end
endmodule : dsssf_top_tb
`default_nettype wire
